// >>> core/pwm_params.svh
// Purpose: offsets, field positions and reset values of the triggered pwm block
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes: definitions only
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_PRESET_ONE 5'h04
`define OFS_PRESET_TWO 5'h08
`define OFS_COUNT 5'h0c
`define OFS_STATUS 5'h10
`define OFS_COMPARE 5'h14

// ==========================================================
// control register fields
`define CTRL_COUNT_EN 0
`define CTRL_TRIG_SRC_LO 1
`define CTRL_TRIG_SRC_HI 2
`define CTRL_TRIG_LEVEL 3
`define CTRL_CLEAR_SEL 4
`define CTRL_RESET_SEL 5
`define CTRL_NO_DEAD 6
`define CTRL_ONE_SHOT 7
`define CTRL_OUT_EN 8
`define CTRL_PWM_MODE 9
`define CTRL_INIT_LEVEL 10
`define CTRL_WIDTH 11

// ==========================================================
// status register fields
`define STAT_WAVE 0
`define STAT_ACTIVE 1
`define STAT_RUN 2
`define STAT_DONE 3

// ==========================================================
// reset values and counter limits
`define CTRL_RESET 11'h000
`define PRESET_RESET 16'h0000
`define COUNT_FULL 16'hffff
`define COUNT_FIRST 16'h0001

`endif

// >>> core/pwm_pkg.sv
// Purpose: shared types of the triggered pwm block
// Assumes: nothing
// Notes: codes of the trigger source follow the control field
package pwm_pkg;

  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'b00,
    SRC_LINE_0 = 2'b01,
    SRC_LINE_1 = 2'b10,
    SRC_LINE_2 = 2'b11
  } trig_src_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARM = 2'b01,
    PH_RUN = 2'b10,
    PH_DONE = 2'b11
  } phase_type;

endpackage

// >>> core/pwm_wave.sv
// Purpose: 16-bit counter, compare registers and waveform of the triggered pwm
// Assumes: active is the combinational trigger validity, not yet sampled
// Notes: wave_d and run_d are next values, registered by the parent
`timescale 1ns/1ps
`include "pwm_params.svh"

module pwm_wave #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic active,
  input wire logic [WIDTH-1:0] preset_one,
  input wire logic [WIDTH-1:0] preset_two,
  input wire logic clear_on_cmp_one,
  input wire logic reset_on_cmp_two,
  input wire logic one_shot,
  output logic wave_d,
  output logic run_d,
  output logic [WIDTH-1:0] count_q,
  output logic [WIDTH-1:0] cmp_one_q,
  output logic [WIDTH-1:0] cmp_two_q,
  output pwm_pkg::phase_type phase_q
);
  import pwm_pkg::*;

  logic wave_q;
  logic wrap;
  logic low_match;
  logic [WIDTH-1:0] rst_cmp;
  phase_type phase_d;

  // ========================================================
  // period end and duty end
  assign wrap = clear_on_cmp_one ? (count_q == cmp_one_q)
              : (count_q == WIDTH'(`COUNT_FULL)); // R10 R16
  assign rst_cmp = reset_on_cmp_two ? cmp_two_q : cmp_one_q; // R13
  assign low_match = (count_q == rst_cmp);
  assign run_d = (phase_d == PH_RUN);

  // ========================================================
  // phase sequence
  always_comb begin
    phase_d = phase_q;
    if (!active) begin
      phase_d = PH_IDLE; // R11
    end else begin
      case (phase_q)
        PH_IDLE: phase_d = PH_ARM; // R8
        PH_ARM: phase_d = PH_RUN;
        PH_RUN: begin
          if (wrap && one_shot) begin
            phase_d = PH_DONE; // R20
          end
        end
        PH_DONE: phase_d = PH_DONE;
        default: phase_d = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ========================================================
  // waveform next value
  always_comb begin
    wave_d = 1'b0;
    if (active) begin
      case (phase_q)
        PH_IDLE: wave_d = 1'b0; // R8
        PH_ARM: wave_d = !low_match; // R9 R18
        PH_RUN: begin
          if (wrap) begin
            wave_d = !one_shot; // R10 R16 R20
          end else if (low_match) begin
            wave_d = 1'b0; // R9 R19
          end else begin
            wave_d = wave_q;
          end
        end
        PH_DONE: wave_d = 1'b0;
        default: wave_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  // ========================================================
  // binary counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (!active) begin
      count_q <= '0; // R5
    end else if (phase_q == PH_ARM) begin
      count_q <= WIDTH'(`COUNT_FIRST); // R9
    end else if (phase_q == PH_RUN) begin
      count_q <= wrap ? '0 : count_q + WIDTH'(1);
    end else begin
      count_q <= '0;
    end
  end

  // ========================================================
  // preset to compare transfer, at rest or at a period boundary
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmp_one_q <= WIDTH'(`PRESET_RESET);
      cmp_two_q <= WIDTH'(`PRESET_RESET);
    end else if (phase_q != PH_RUN || wrap) begin
      cmp_one_q <= preset_one; // R6 R15
      cmp_two_q <= preset_two;
    end
  end

endmodule // pwm_wave

// >>> core/triggered_pwm_output.sv
// Purpose: gated pwm generator for three switch gate pin pairs, Avalon-MM registers
// Assumes: trigger lines synchronous to clk; clk is the count clock
// Notes: one wait state on every bus access
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pwm_params.svh"

// What this block does
// [R1] source field 01,10,11 picks trigger line 0,1,2; 00 picks software enable
// [R2] line trigger counts while line is high if level bit 1, low if 0
// [R3] software mode counts while count enable is 1; level bit ignored
// [R4] software programs source field before setting count enable
// [R5] counter cleared to zero whenever counting stops
// [R6] presets move into compare registers on the count clock
// [R7] software leaves presets alone while output operation runs
// [R8] operation valid one clock after trigger; output low until next clock
// [R9] output high from count zero to compare-two match; first cycle from one
// [R10] standard variant: low after match, full overflow sets high and period
// [R11] trigger invalid: timer initialised and outputs forced low at once
// [R12] standard variant: software selects overflow as clear source
// [R13] reset source bit picks compare-one or compare-two match for low
// [R14] count enable 0 holds both complementary outputs low
// [R15] high-precision variant: compare one gives period, compare two duty
// [R16] high-precision variant: compare-one match clears counter, output high
// [R17] high-precision variant: software sets clear and reset source bits to 1
// [R18] output starts low, first rises on second clock after trigger
// [R19] compare two above compare one keeps output high in high-precision
// [R20] one-shot bit gives one pulse instead of a repeating wave
// [R21] software sets output enable and pwm mode, clears initial level
// [R22] three pin pairs A, B, C of primary and companion outputs
// [R23] selected trigger level sampled on the count clock edge
module triggered_pwm_output #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ext_trigger_line_0,
  input wire logic ext_trigger_line_1,
  input wire logic ext_trigger_line_2,
  output logic primary_output_a,
  output logic companion_output_a,
  output logic primary_output_b,
  output logic companion_output_b,
  output logic primary_output_c,
  output logic companion_output_c
);
  import pwm_pkg::*;

  // ========================================================
  // declarations
  logic [`CTRL_WIDTH-1:0] ctrl_q;
  logic [WIDTH-1:0] preset_one_q;
  logic [WIDTH-1:0] preset_two_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic [2:0] primary_q;
  logic [2:0] companion_q;
  logic active_q;
  logic [31:0] read_mux;
  logic [31:0] ctrl_merged;
  logic bus_req;
  logic wr_take;
  logic count_enable_bit;
  trig_src_type trigger_source_field;
  logic trigger_level_select;
  logic counter_clear_source_sel;
  logic output_reset_source_sel;
  logic no_dead_time_bit;
  logic one_shot_select;
  logic triggered_output_enable;
  logic pwm_mode_bit;
  logic initial_level_bit;
  logic line_level;
  logic active_d;
  logic pins_on;
  logic wave_d;
  logic run_d;
  logic [WIDTH-1:0] binary_counter_value;
  logic [WIDTH-1:0] compare_reg_one;
  logic [WIDTH-1:0] compare_reg_two;
  phase_type phase_q;

  // ========================================================
  // helpers
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] lanes
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_reg(
    input logic [4:0] addr,
    input logic [4:0] ofs
  );
    return addr[4:2] == ofs[4:2];
  endfunction

  // ========================================================
  // control field views
  assign count_enable_bit = ctrl_q[`CTRL_COUNT_EN];
  assign trigger_source_field = trig_src_type'(ctrl_q[`CTRL_TRIG_SRC_HI:`CTRL_TRIG_SRC_LO]);
  assign trigger_level_select = ctrl_q[`CTRL_TRIG_LEVEL];
  assign counter_clear_source_sel = ctrl_q[`CTRL_CLEAR_SEL];
  assign output_reset_source_sel = ctrl_q[`CTRL_RESET_SEL];
  assign no_dead_time_bit = ctrl_q[`CTRL_NO_DEAD];
  assign one_shot_select = ctrl_q[`CTRL_ONE_SHOT];
  assign triggered_output_enable = ctrl_q[`CTRL_OUT_EN];
  assign pwm_mode_bit = ctrl_q[`CTRL_PWM_MODE];
  assign initial_level_bit = ctrl_q[`CTRL_INIT_LEVEL];

  // ========================================================
  // Avalon-MM slave: one wait state, then the access completes
  assign bus_req = (read || write) && waitrequest_q;
  assign wr_take = write && !waitrequest_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest_q <= 1'b1;
    end else if (bus_req) begin
      waitrequest_q <= 1'b0;
    end else begin
      waitrequest_q <= 1'b1;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    if (is_reg(address, `OFS_CTRL)) begin
      read_mux[`CTRL_WIDTH-1:0] = ctrl_q;
    end else if (is_reg(address, `OFS_PRESET_ONE)) begin
      read_mux[WIDTH-1:0] = preset_one_q;
    end else if (is_reg(address, `OFS_PRESET_TWO)) begin
      read_mux[WIDTH-1:0] = preset_two_q;
    end else if (is_reg(address, `OFS_COUNT)) begin
      read_mux[WIDTH-1:0] = binary_counter_value;
    end else if (is_reg(address, `OFS_STATUS)) begin
      read_mux[`STAT_WAVE] = primary_q[0];
      read_mux[`STAT_ACTIVE] = active_q;
      read_mux[`STAT_RUN] = (phase_q == PH_RUN);
      read_mux[`STAT_DONE] = (phase_q == PH_DONE);
    end else if (is_reg(address, `OFS_COMPARE)) begin
      read_mux = {compare_reg_two, compare_reg_one};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (bus_req && read) begin
      readdata_q <= read_mux;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // ========================================================
  // writable registers; presets are not locked while running
  assign ctrl_merged = merge_bytes(32'(ctrl_q), writedata, byteenable);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_take && is_reg(address, `OFS_CTRL)) begin
      ctrl_q <= ctrl_merged[`CTRL_WIDTH-1:0]; // R3
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      preset_one_q <= WIDTH'(`PRESET_RESET);
    end else if (wr_take && is_reg(address, `OFS_PRESET_ONE)) begin
      preset_one_q <= WIDTH'(merge_bytes(32'(preset_one_q), writedata, byteenable));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      preset_two_q <= WIDTH'(`PRESET_RESET);
    end else if (wr_take && is_reg(address, `OFS_PRESET_TWO)) begin
      preset_two_q <= WIDTH'(merge_bytes(32'(preset_two_q), writedata, byteenable));
    end
  end

  // ========================================================
  // trigger selection and validity
  always_comb begin
    case (trigger_source_field)
      SRC_LINE_0: line_level = ext_trigger_line_0; // R1
      SRC_LINE_1: line_level = ext_trigger_line_1;
      SRC_LINE_2: line_level = ext_trigger_line_2;
      SRC_SOFTWARE: line_level = 1'b1;
      default: line_level = 1'b0;
    endcase
  end

  always_comb begin
    if (!count_enable_bit) begin
      active_d = 1'b0; // R14
    end else if (trigger_source_field == SRC_SOFTWARE) begin
      active_d = 1'b1; // R3
    end else begin
      active_d = (line_level == trigger_level_select); // R2
    end
  end

  // level seen at each clock edge only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d; // R23
    end
  end

  // ========================================================
  // counter and waveform core
  pwm_wave #(
    .WIDTH(WIDTH)
  ) u_wave (
    .clk(clk),
    .reset_n(reset_n),
    .active(active_d),
    .preset_one(preset_one_q),
    .preset_two(preset_two_q),
    .clear_on_cmp_one(counter_clear_source_sel),
    .reset_on_cmp_two(output_reset_source_sel),
    .one_shot(one_shot_select),
    .wave_d(wave_d),
    .run_d(run_d),
    .count_q(binary_counter_value),
    .cmp_one_q(compare_reg_one),
    .cmp_two_q(compare_reg_two),
    .phase_q(phase_q)
  );

  // ========================================================
  // pin pairs
  assign pins_on = triggered_output_enable && pwm_mode_bit && !initial_level_bit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      primary_q <= 3'h0;
    end else if (pins_on && active_d) begin
      primary_q <= {3{wave_d}}; // R22
    end else begin
      primary_q <= 3'h0; // R11 R14
    end
  end

  // companion is the inverse only while running without dead time
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      companion_q <= 3'h0;
    end else if (pins_on && active_d && run_d && no_dead_time_bit) begin
      companion_q <= {3{!wave_d}}; // R22
    end else begin
      companion_q <= 3'h0; // R14
    end
  end

  assign primary_output_a = primary_q[0];
  assign primary_output_b = primary_q[1];
  assign primary_output_c = primary_q[2];
  assign companion_output_a = companion_q[0];
  assign companion_output_b = companion_q[1];
  assign companion_output_c = companion_q[2];

endmodule // triggered_pwm_output

// >>> tb/pwm_props.sv
// Purpose: bus and pin checks of the triggered pwm block
// Assumes: one wait state per access
// Notes: keeps a shadow of the control word to know the gate
`timescale 1ns/1ps
module pwm_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic ext_trigger_line_0,
  input wire logic ext_trigger_line_1,
  input wire logic ext_trigger_line_2,
  input wire logic primary_output_a,
  input wire logic companion_output_a,
  input wire logic primary_output_b,
  input wire logic companion_output_b,
  input wire logic primary_output_c,
  input wire logic companion_output_c
);
  logic [10:0] ctrl_q;
  logic sel_line;
  logic act;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // shadow of the trigger gate
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= 11'h000;
    end else if (write && !waitrequest && address[4:2] == 3'h0) begin
      if (byteenable[0]) ctrl_q[7:0] <= writedata[7:0];
      if (byteenable[1]) ctrl_q[10:8] <= writedata[10:8];
    end
  end
  always_comb begin
    case (ctrl_q[2:1])
      2'h1: sel_line = ext_trigger_line_0;
      2'h2: sel_line = ext_trigger_line_1;
      default: sel_line = ext_trigger_line_2;
    endcase
    act = ctrl_q[0] && (ctrl_q[2:1] == 2'h0 || sel_line == ctrl_q[3]);
  end
  // ==========================================
  // properties
  sequence access_s;
    waitrequest ##1 !waitrequest ##1 waitrequest;
  endsequence
  sequence quiet_s;
    !primary_output_a && !companion_output_a;
  endsequence
  wait_one_a: assert property ((read || write) && waitrequest |-> access_s)
    else $error("bus access not answered after one wait cycle");
  no_stray_a: assert property (!waitrequest |-> $past(read || write))
    else $error("wait released without a request");
  unmapped_zero_a: assert property (read && !waitrequest && address[4:2] > 3'h5
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  idle_low_a: assert property (!act |=> quiet_s)
    else $error("outputs not low while gate closed");
  arm_low_a: assert property ($rose(act) |=> quiet_s)
    else $error("output high in the arming cycle");
  rise_gate_a: assert property ($rose(primary_output_a) |->
    $past(act, 1) && $past(act, 2)) else $error("output rose without two gated edges");
  pin_pairs_a: assert property (primary_output_b == primary_output_a &&
    primary_output_c == primary_output_a && companion_output_b == companion_output_a &&
    companion_output_c == companion_output_a) else $error("pin pairs differ");
  comp_inverse_a: assert property (companion_output_a |-> !primary_output_a)
    else $error("both outputs of a pair high");
endmodule // pwm_props

bind triggered_pwm_output pwm_props u_props (.clk, .reset_n, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .ext_trigger_line_0,
  .ext_trigger_line_1, .ext_trigger_line_2, .primary_output_a, .companion_output_a,
  .primary_output_b, .companion_output_b, .primary_output_c, .companion_output_c);

// >>> tb/trigger_model.sv
// Purpose: far side model of the three trigger lines
// Assumes: lines change only on clk edges
// Notes: levels follow the request one edge later
`timescale 1ns/1ps
module trigger_model (
  input wire logic clk,
  input wire logic [2:0] level_req,
  output logic ext_trigger_line_0,
  output logic ext_trigger_line_1,
  output logic ext_trigger_line_2
);
  always_ff @(posedge clk) begin
    ext_trigger_line_0 <= level_req[0];
    ext_trigger_line_1 <= level_req[1];
    ext_trigger_line_2 <= level_req[2];
  end
endmodule // trigger_model

// >>> tb/triggered_pwm_output_bench.sv
// Purpose: self-checking bench of the triggered pwm block
// Assumes: one wait state per bus access
// Notes: run lengths of primary_output_a are checked from queues
`timescale 1ns/1ps
`include "pwm_params.svh"
module triggered_pwm_output_bench;
  localparam logic [31:0] hp_ctrl = 32'h0000_0370;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [2:0] level_req = 3'h0;
  logic [31:0] readdata;
  logic waitrequest, ext_trigger_line_0, ext_trigger_line_1, ext_trigger_line_2;
  logic primary_output_a, primary_output_b, primary_output_c;
  logic companion_output_a, companion_output_b, companion_output_c;
  logic pp = 1'b0;
  logic [31:0] exp_rd[$];
  int exp_hi[$];
  int exp_lo[$];
  int fail_count = 0;
  int tests_run = 0;
  int hi_len = 0;
  int lo_len = 0;
  int n, p1, p2;
  always #50 clk = ~clk;
  triggered_pwm_output u_dut (.clk, .reset_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .ext_trigger_line_0, .ext_trigger_line_1,
    .ext_trigger_line_2, .primary_output_a, .companion_output_a, .primary_output_b,
    .companion_output_b, .primary_output_c, .companion_output_c);
  trigger_model u_trig (.clk, .level_req, .ext_trigger_line_0, .ext_trigger_line_1,
    .ext_trigger_line_2);
  // ==========================================
  // compares and bus master
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value at %0t: run %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    write <= 1'b0;
    read <= 1'b0;
    if (k == 20) begin
      fail_count++;
      $display("wrong value at %0t: no bus answer", $time);
      test_done;
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_pin(input logic v, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (primary_output_a !== v && k < lim);
    @(negedge clk);
  endtask
  task automatic test_done;
    if (exp_rd.size() + exp_hi.size() + exp_lo.size() > 0) fail_count++;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // monitor of read data and run lengths
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) chk_rd(readdata, exp_rd.pop_front());
    if (primary_output_a === 1'b1 && !pp) begin
      if (exp_lo.size() > 0) chk_len(lo_len, exp_lo.pop_front());
      hi_len = 1;
    end else if (primary_output_a === 1'b1) begin
      hi_len++;
    end else if (pp) begin
      if (exp_hi.size() > 0) chk_len(hi_len, exp_hi.pop_front());
      lo_len = 1;
    end else begin
      lo_len++;
    end
    pp = (primary_output_a === 1'b1);
  end
  initial begin
    #2000000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done;
  end
  // ==========================================
  // scenarios
  initial begin
    n = $urandom(40);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b1, 5'h18, 32'hffff_ffff);
    for (int a = 0; a < 8; a++) rd(5'(a * 4), 32'h0);
    p1 = 12 + $urandom % 8;
    p2 = 1 + $urandom % (p1 - 7);
    bus(1'b1, `OFS_PRESET_ONE, 32'(p1));
    bus(1'b1, `OFS_PRESET_TWO, 32'(p2));
    exp_hi = '{p2, p2 + 1, p2 + 1};
    bus(1'b1, `OFS_CTRL, hp_ctrl | 32'h1);
    wait_pin(1'b1, 50, n);
    chk_len(n, 3);
    exp_lo = '{p1 - p2, p1 - p2};
    repeat (3) begin
      wait_pin(1'b1, 50, n);
      wait_pin(1'b0, 50, n);
      chk_pin(companion_output_a, 1'b1);
    end
    bus(1'b1, `OFS_CTRL, hp_ctrl);
    rd(`OFS_COUNT, 32'h0);
    rd(`OFS_COMPARE, {16'(p2), 16'(p1)});
    bus(1'b1, `OFS_PRESET_ONE, 32'd20);
    bus(1'b1, `OFS_PRESET_TWO, 32'd10);
    for (int s = 1; s < 4; s++) begin
      for (int lv = 0; lv < 2; lv++) begin
        @(posedge clk);
        level_req <= 3'(lv ? 7 - (1 << (s - 1)) : 1 << (s - 1));
        bus(1'b1, `OFS_CTRL, hp_ctrl | 32'(s << 1) | 32'(lv << 3));
        bus(1'b1, `OFS_CTRL, hp_ctrl | 32'(s << 1) | 32'(lv << 3) | 32'h1);
        wait_pin(1'b1, 6, n);
        chk_len(n, 6);
        @(posedge clk);
        level_req <= ~level_req;
        wait_pin(1'b1, 20, n);
        chk_len(n, 4);
        exp_hi.push_back(4);
        @(posedge clk);
        level_req <= ~level_req;
        wait_pin(1'b0, 20, n);
        bus(1'b1, `OFS_CTRL, hp_ctrl);
      end
    end
    bus(1'b1, `OFS_PRESET_ONE, 32'd7);
    bus(1'b1, `OFS_PRESET_TWO, 32'd5);
    for (int r = 0; r < 2; r++) begin
      exp_hi.push_back(r ? 5 : 7);
      bus(1'b1, `OFS_CTRL, 32'h341 | 32'(r << 5));
      wait_pin(1'b1, 10, n);
      wait_pin(1'b0, 20, n);
      bus(1'b1, `OFS_CTRL, 32'h340);
      rd(`OFS_COUNT, 32'h0);
    end
    bus(1'b1, `OFS_PRESET_ONE, 32'd10);
    bus(1'b1, `OFS_PRESET_TWO, 32'd4);
    exp_hi.push_back(4);
    bus(1'b1, `OFS_CTRL, hp_ctrl | 32'h81);
    wait_pin(1'b1, 10, n);
    wait_pin(1'b0, 20, n);
    wait_pin(1'b1, 40, n);
    chk_len(n, 40);
    rd(`OFS_STATUS, 32'ha);
    bus(1'b1, `OFS_CTRL, hp_ctrl);
    bus(1'b1, `OFS_PRESET_ONE, 32'd6);
    bus(1'b1, `OFS_PRESET_TWO, 32'd9);
    bus(1'b1, `OFS_CTRL, hp_ctrl | 32'h1);
    wait_pin(1'b1, 10, n);
    wait_pin(1'b0, 40, n);
    chk_len(n, 40);
    rd(`OFS_STATUS, 32'h7);
    bus(1'b1, `OFS_CTRL, hp_ctrl);
    bus(1'b1, `OFS_CTRL, hp_ctrl | 32'h401);
    wait_pin(1'b1, 10, n);
    chk_len(n, 10);
    bus(1'b1, `OFS_CTRL, hp_ctrl);
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule // triggered_pwm_output_bench
